// file: inc/bpsc_pkg.sv
// Purpose: shared constants and types for the bus pin state control block
// Assumes: one pin slot per controlled bus pin, indexed by the PIN_ names
// Notes: action codes say how a pin is driven in the current chip state
package bpsc_pkg;

  // ****************************************
  // pin slots
  // ****************************************
  localparam int PIN_W = 12;
  localparam int PIN_ADS = 0;  // address_strobe
  localparam int PIN_RDS = 1;  // read strobe
  localparam int PIN_UWS = 2;  // upper_write_strobe
  localparam int PIN_LWS = 3;  // lower_write_strobe
  localparam int PIN_CS0 = 4;  // chip_select_0, then 1..3
  localparam int PIN_SH = 8;   // lower column / wait / request out
  localparam int PIN_GNT = 9;  // bus grant output
  localparam int PIN_BRQ = 10; // bus_request_input
  localparam int PIN_CAS = 11; // column strobe
  localparam logic [PIN_W-1:0] PINS_OFF = 12'h000;

  // ****************************************
  // chip states
  // ****************************************
  typedef enum logic [2:0] {
    ST_PWRUP  = 3'h0,
    ST_HWSTBY = 3'h1,
    ST_POR    = 3'h2,
    ST_MRST   = 3'h3,
    ST_EXEC   = 3'h4,
    ST_SWSTBY = 3'h5,
    ST_BREL   = 3'h6
  } bpsc_state_type;

  // ****************************************
  // pin actions
  // ****************************************
  typedef enum logic [2:0] {
    ACT_Z    = 3'h0,
    ACT_HI   = 3'h1,
    ACT_LO   = 3'h2,
    ACT_KEEP = 3'h3,
    ACT_PORT = 3'h4,
    ACT_FN   = 3'h5,
    ACT_IN   = 3'h6
  } bpsc_act_type;

  // ****************************************
  // configuration bits
  // ****************************************
  typedef struct packed {
    logic standby_output_keep;
    logic wait_input_enable;
    logic bus_release_allow;
    logic bus_request_out_enable;
    logic dram_space_select;
    logic lower_column_enable;
    logic dram_mode;  // operating modes 4 to 6
  } bpsc_cfg_type;

  // ****************************************
  // pin bundle
  // ****************************************
  typedef struct packed {
    logic [PIN_W-1:0] o;
    logic [PIN_W-1:0] oe;
  } bpsc_pins_type;

endpackage : bpsc_pkg

// file: rtl/bpsc_top.sv
// Purpose: drive the external bus control pins for each chip state
// Assumes: pins synchronous to sys_clk; bus controller supplies fn_o
// Notes: pin outputs lag the chip state by one clock
`timescale 1ns/1ps

// How it works
// - held pin: input floats, output keeps level
// - manual reset pins change after bus cycle
// - power-on reset: strobes, chip_select_0 high
// - manual reset shared pin per enable
// - software standby shared pin per enable
// - bus release shared pin per enable
// - execution shared pin function per enable
// - grant low in release when allowed
// - standby strobes float or high by keep
// - column strobe needs dram_space_select in modes
// - nmi rise then high enters power-on reset
// - nmi low after power-up: stay in power-up
// - oscillator starts after standby_pin high
// - reset release starts power-on exception handling
module bpsc_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // chip control pins
  input wire logic nmi_pin,
  input wire logic standby_pin,
  input wire logic reset_pin_n,
  // internal requests
  input wire logic manual_reset_req,
  input wire logic sw_standby_req,
  input wire logic wake_req,
  input wire logic bus_cycle_busy,
  // configuration
  input wire bpsc_pkg::bpsc_cfg_type cfg,
  // port and function sources
  input wire logic [bpsc_pkg::PIN_W-1:0] port_dout,
  input wire logic [bpsc_pkg::PIN_W-1:0] port_ddr,
  input wire logic [bpsc_pkg::PIN_W-1:0] fn_o,
  // pins
  input wire logic [bpsc_pkg::PIN_W-1:0] pin_in,
  output bpsc_pkg::bpsc_pins_type pins_r,
  // status
  output bpsc_pkg::bpsc_state_type chip_state_r,
  output logic por_start_r,
  output logic osc_run_r,
  output logic stall_request_input_r,
  output logic bus_request_input_r
);
  import bpsc_pkg::*;

  // ****************************************
  // pin action per state
  // ****************************************
  function automatic bpsc_act_type pin_act(
    input int i,
    input bpsc_state_type st,
    input bpsc_cfg_type c,
    input logic d
  );
    bpsc_act_type a;
    logic keep;
    logic none;
    a = ACT_KEEP;
    keep = c.standby_output_keep;
    none = !(c.bus_request_out_enable || c.wait_input_enable
             || c.lower_column_enable);
    if (st == ST_HWSTBY) begin
      a = ACT_Z;
    end else if (st == ST_PWRUP) begin
      a = ACT_KEEP;
    end else if (st == ST_POR) begin
      a = (i <= PIN_CS0) ? ACT_HI : ACT_Z;
    end else if (i < PIN_CS0) begin
      case (st)
        ST_MRST: a = ACT_HI;
        ST_SWSTBY: a = keep ? ACT_HI : ACT_Z;
        ST_BREL: a = ACT_Z;
        default: a = ACT_FN;
      endcase
    end else if (i < PIN_SH) begin
      case (st)
        ST_MRST: a = d ? ACT_HI : ACT_Z;
        ST_SWSTBY: a = (d && keep) ? ACT_HI : ACT_Z;
        ST_BREL: a = ACT_Z;
        default: a = d ? ACT_FN : ACT_IN;
      endcase
    end else if (i == PIN_SH) begin
      if (none) begin
        a = (st == ST_EXEC) ? ACT_PORT : ACT_KEEP;
      end else if (c.bus_request_out_enable) begin
        a = (st == ST_SWSTBY) ? ACT_KEEP : ACT_FN;
      end else if (c.wait_input_enable) begin
        a = (st == ST_EXEC) ? ACT_IN : ACT_Z;
      end else begin
        case (st)
          ST_MRST: a = ACT_HI;
          ST_SWSTBY: a = keep ? ACT_FN : ACT_Z;
          ST_BREL: a = ACT_Z;
          default: a = ACT_FN;
        endcase
      end
    end else if (i == PIN_GNT || i == PIN_BRQ) begin
      if (!c.bus_release_allow) begin
        a = (st == ST_EXEC) ? ACT_PORT : ACT_KEEP;
      end else if (i == PIN_GNT) begin
        a = (st == ST_BREL) ? ACT_LO : ACT_HI;
      end else begin
        a = (st == ST_MRST || st == ST_EXEC) ? ACT_IN : ACT_Z;
      end
    end else begin
      if (!c.dram_mode) begin
        a = (st == ST_EXEC) ? ACT_PORT : ACT_KEEP;
      end else begin
        case (st)
          ST_MRST: a = c.dram_space_select ? ACT_HI : ACT_KEEP;
          ST_SWSTBY: begin
            if (!c.dram_space_select) begin
              a = ACT_KEEP;
            end else begin
              a = keep ? ACT_FN : ACT_Z;
            end
          end
          ST_BREL: a = ACT_Z;
          default: a = c.dram_space_select ? ACT_FN : ACT_IN;
        endcase
      end
    end
    return a;
  endfunction : pin_act

  // ****************************************
  // pin drive from action
  // ****************************************
  // returns {oe, o}
  function automatic logic [1:0] pin_drive(
    input bpsc_act_type a,
    input logic o_prev,
    input logic oe_prev,
    input logic dout,
    input logic ddr,
    input logic fn
  );
    logic [1:0] r;
    r = {1'b0, o_prev};
    case (a)
      ACT_HI: r = 2'h3;
      ACT_LO: r = 2'h2;
      ACT_KEEP: r = {oe_prev & ddr, o_prev};
      ACT_PORT: r = {ddr, dout};
      ACT_FN: r = {1'b1, fn};
      default: r = {1'b0, o_prev};
    endcase
    return r;
  endfunction : pin_drive

  // ****************************************
  // chip state sequencing
  // ****************************************
  bpsc_state_type st_nxt;
  logic nmi_low_seen_r;
  logic nmi_low_seen_nxt;
  logic mrst_done_r;
  logic mrst_done_nxt;
  wire logic bus_req_w = cfg.bus_release_allow & ~pin_in[PIN_BRQ];
  wire logic rst_hold_w = !reset_pin_n;
  wire logic defer_w = (chip_state_r == ST_MRST) && !mrst_done_r
                       && bus_cycle_busy;

  always_comb begin
    st_nxt = chip_state_r;
    if (!standby_pin) begin
      st_nxt = ST_HWSTBY;
    end else begin
      case (chip_state_r)
        ST_HWSTBY: if (osc_run_r) st_nxt = ST_POR;
        ST_PWRUP: if (nmi_low_seen_r && nmi_pin) st_nxt = ST_POR;
        ST_POR: if (!rst_hold_w) st_nxt = ST_EXEC;
        ST_EXEC: begin
          if (rst_hold_w) begin
            st_nxt = ST_POR;
          end else if (manual_reset_req) begin
            st_nxt = ST_MRST;
          end else if (sw_standby_req && !bus_cycle_busy) begin
            st_nxt = ST_SWSTBY;
          end else if (bus_req_w && !bus_cycle_busy) begin
            st_nxt = ST_BREL;
          end
        end
        ST_MRST: begin
          if (rst_hold_w) begin
            st_nxt = ST_POR;
          end else if (!manual_reset_req) begin
            st_nxt = ST_EXEC;
          end
        end
        ST_SWSTBY: begin
          if (rst_hold_w) begin
            st_nxt = ST_POR;
          end else if (wake_req) begin
            st_nxt = ST_EXEC;
          end
        end
        ST_BREL: begin
          if (rst_hold_w) begin
            st_nxt = ST_POR;
          end else if (!bus_req_w) begin
            st_nxt = ST_EXEC;
          end
        end
        default: st_nxt = ST_PWRUP;
      endcase
    end
  end

  // low level on nmi after power-up arms the move to power-on reset once nmi goes high
  assign nmi_low_seen_nxt = nmi_low_seen_r | !nmi_pin;
  // bus cycle ends once; the flag clears on leaving manual reset
  assign mrst_done_nxt = (chip_state_r == ST_MRST)
                         && (mrst_done_r || !bus_cycle_busy);

  // ****************************************
  // pin outputs
  // ****************************************
  bpsc_pins_type pins_nxt;
  bpsc_act_type act_w [PIN_W];

  for (genvar g = 0; g < PIN_W; g++) begin : g_pin
    wire logic dfr_w;
    wire bpsc_act_type eff_w;
    assign act_w[g] = pin_act(g, chip_state_r, cfg, port_ddr[g]);
    // a strobe must not be cut mid-cycle
    assign dfr_w = defer_w && (act_w[g] == ACT_HI) && (g != PIN_GNT);
    assign eff_w = dfr_w ? ACT_FN : act_w[g];
    assign {pins_nxt.oe[g], pins_nxt.o[g]} = pin_drive(eff_w,
      pins_r.o[g], pins_r.oe[g], port_dout[g], port_ddr[g], fn_o[g]);
  end

  wire logic stall_nxt = (chip_state_r == ST_EXEC) && cfg.wait_input_enable
                         && !cfg.bus_request_out_enable
                         && pin_in[PIN_SH];
  wire logic por_nxt = (chip_state_r == ST_POR) && (st_nxt == ST_EXEC);

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chip_state_r <= ST_PWRUP;
      nmi_low_seen_r <= 1'b0;
      mrst_done_r <= 1'b0;
      pins_r <= '{o: PINS_OFF, oe: PINS_OFF};
      por_start_r <= 1'b0;
      osc_run_r <= 1'b0;
      stall_request_input_r <= 1'b0;
      bus_request_input_r <= 1'b0;
    end else if (clk_en) begin
      chip_state_r <= st_nxt;
      nmi_low_seen_r <= nmi_low_seen_nxt;
      mrst_done_r <= mrst_done_nxt;
      pins_r <= pins_nxt;
      por_start_r <= por_nxt;
      osc_run_r <= standby_pin;
      stall_request_input_r <= stall_nxt;
      bus_request_input_r <= bus_req_w;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_hwstby_float;
    chip_state_r == ST_HWSTBY && clk_en |=> pins_r.oe == PINS_OFF;
  endproperty
  a_hwstby_float: assert property (p_hwstby_float)
    else $error("pin driven in hardware standby");

  property p_por_pins;
    chip_state_r == ST_POR && clk_en |=>
      pins_r.oe[PIN_CS0:0] == 5'h1f && pins_r.o[PIN_CS0:0] == 5'h1f
      && pins_r.oe[PIN_W-1:PIN_CS0+1] == 7'h00;
  endproperty
  a_por_pins: assert property (p_por_pins)
    else $error("wrong pin state in power-on reset");

  property p_por_start;
    por_start_r && $past(clk_en) |-> $past(chip_state_r) == ST_POR && chip_state_r == ST_EXEC;
  endproperty
  a_por_start: assert property (p_por_start)
    else $error("exception start without reset release");

  property p_grant_low;
    chip_state_r == ST_BREL && cfg.bus_release_allow && clk_en |=>
      pins_r.oe[PIN_GNT] && !pins_r.o[PIN_GNT];
  endproperty
  a_grant_low: assert property (p_grant_low)
    else $error("grant not low in bus release");

  property p_sw_strobe_z;
    chip_state_r == ST_SWSTBY && !cfg.standby_output_keep && clk_en |=>
      pins_r.oe[PIN_LWS:PIN_ADS] == 4'h0;
  endproperty
  a_sw_strobe_z: assert property (p_sw_strobe_z)
    else $error("strobe driven in standby without keep");

  property p_defer;
    defer_w && clk_en |=> pins_r.o[PIN_LWS:PIN_ADS] == $past(fn_o[PIN_LWS:PIN_ADS]);
  endproperty
  a_defer: assert property (p_defer)
    else $error("strobe changed before bus cycle end");

  property p_osc;
    $rose(osc_run_r) |-> $past(standby_pin);
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator start without standby high");

  property p_wait_z;
    chip_state_r == ST_EXEC && cfg.wait_input_enable
      && !cfg.bus_request_out_enable && clk_en |=> !pins_r.oe[PIN_SH];
  endproperty
  a_wait_z: assert property (p_wait_z)
    else $error("shared pin driven while wait enabled");

  property p_nmi_por;
    chip_state_r == ST_PWRUP && standby_pin && nmi_low_seen_r && nmi_pin
      && clk_en |=> chip_state_r == ST_POR;
  endproperty
  a_nmi_por: assert property (p_nmi_por)
    else $error("no power-on reset after nmi rise");

endmodule : bpsc_top

// file: verification/bpsc_far_model.sv
// Purpose: far side of the bus pins: memories with a wait line and an outside bus master
// Assumes: pins_r oe high means the block drives the slot
// Notes: undriven slots without a pull show a pattern that flips each cycle
`timescale 1ns/1ps
module bpsc_far_model (
  // clock
  input wire logic sys_clk,
  // commands from the bench
  input wire logic stall,
  input wire logic bus_request_input_req,
  // pins
  input wire bpsc_pkg::bpsc_pins_type pins,
  output logic [bpsc_pkg::PIN_W-1:0] pin_in
);
  import bpsc_pkg::*;
  logic alt_r = 1'b0;
  always @(posedge sys_clk) alt_r <= ~alt_r;
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      pin_in[i] = pins.oe[i] ? pins.o[i] : alt_r ^ i[0];
    end
    // wait line has a pull-up; a slow memory pulls it low
    if (!pins.oe[PIN_SH]) pin_in[PIN_SH] = ~stall;
    // request line is active low with a pull-up
    if (!pins.oe[PIN_BRQ]) pin_in[PIN_BRQ] = ~bus_request_input_req;
  end
endmodule : bpsc_far_model

// file: verification/bus_pin_state_control_bench.sv
// Purpose: self-checking bench for the bus pin state control block
// Assumes: pins settle one edge after the chip state changes
// Notes: expectations are noted in a queue and compared by a watcher process
`timescale 1ns/1ps
module bus_pin_state_control_bench;
  import bpsc_pkg::*;
  typedef struct {int sel; logic [11:0] mask; logic [11:0] val;} bpsc_note_type;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic nmi_pin = 1'b0;
  logic standby_pin = 1'b1;
  logic reset_pin_n = 1'b0;
  logic manual_reset_req = 1'b0;
  logic sw_standby_req = 1'b0;
  logic wake_req = 1'b0;
  logic bus_cycle_busy = 1'b0;
  logic stall = 1'b0;
  logic bus_request_input_req = 1'b0;
  bpsc_cfg_type cfg = '0;
  logic [11:0] port_dout = 12'h000;
  logic [11:0] port_ddr = 12'h0f0;
  logic [11:0] fn_o = 12'hfff;
  logic [11:0] pin_in;
  bpsc_pins_type pins_r;
  bpsc_state_type chip_state_r;
  logic por_start_r, osc_run_r, stall_request_input_r, bus_request_input_r;
  logic [7:0] rnd = 8'h35;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  bpsc_note_type notes[$];
  event chk_ev;
  string names[7] = '{"state", "pin_o", "pin_oe", "por_start", "osc_run", "bus_request_input_in", "stall"};

  bpsc_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .nmi_pin(nmi_pin),
    .standby_pin(standby_pin), .reset_pin_n(reset_pin_n), .manual_reset_req(manual_reset_req),
    .sw_standby_req(sw_standby_req), .wake_req(wake_req), .bus_cycle_busy(bus_cycle_busy),
    .cfg(cfg), .port_dout(port_dout), .port_ddr(port_ddr), .fn_o(fn_o), .pin_in(pin_in),
    .pins_r(pins_r), .chip_state_r(chip_state_r), .por_start_r(por_start_r),
    .osc_run_r(osc_run_r), .stall_request_input_r(stall_request_input_r),
    .bus_request_input_r(bus_request_input_r));
  bpsc_far_model u_far (.sys_clk(sys_clk), .stall(stall), .bus_request_input_req(bus_request_input_req),
    .pins(pins_r), .pin_in(pin_in));

  always #4 sys_clk = ~sys_clk;

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic note(input int sel, input logic [11:0] mask, input logic [11:0] val);
    notes.push_back('{sel, mask, val});
    -> chk_ev;
  endtask : note

  task automatic note_st(input bpsc_state_type st);
    note(0, 12'h007, {9'h000, st});
  endtask : note_st

  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : step

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // ****************************************
  // watcher
  // ****************************************
  always @(chk_ev) begin
    bpsc_note_type n;
    logic [11:0] s;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.sel)
        0: s = {9'h000, chip_state_r};
        1: s = pins_r.o;
        2: s = pins_r.oe;
        3: s = {11'h000, por_start_r};
        4: s = {11'h000, osc_run_r};
        5: s = {11'h000, bus_request_input_r};
        default: s = {11'h000, stall_request_input_r};
      endcase
      check(names[n.sel], s & n.mask, n.val);
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      conclude();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    step(10);
    rst_n = 1'b1;
    step(3);
    nmi_pin = 1'b1;
    step(4);
    note_st(ST_POR);
    note(2, 12'hfff, 12'h01f);
    note(1, 12'h01f, 12'h01f);
    note(4, 12'h001, 12'h001);
    $display("test power_up done");
    reset_pin_n = 1'b1;
    step(1);
    note_st(ST_EXEC);
    note(3, 12'h001, 12'h001);
    step(1);
    note(3, 12'h001, 12'h000);
    $display("test por_release done");
    cfg.lower_column_enable = 1'b1;
    cfg.dram_mode = 1'b1;
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr_next(rnd);
      fn_o = {4'h0, rnd};
      port_dout = {rnd, ~rnd[3:0]};
      step(2);
      note(2, 12'h9ff, 12'h1ff);
      note(1, 12'h1ff, {3'h0, fn_o[8:0]});
    end
    $display("test exec done");
    fn_o = 12'h1f0;
    bus_cycle_busy = 1'b1;
    manual_reset_req = 1'b1;
    step(3);
    note_st(ST_MRST);
    note(1, 12'h00f, 12'h000);
    bus_cycle_busy = 1'b0;
    step(3);
    note(1, 12'h1ff, 12'h1ff);
    note(2, 12'h1ff, 12'h1ff);
    manual_reset_req = 1'b0;
    step(2);
    note_st(ST_EXEC);
    $display("test manual_reset done");
    sw_standby_req = 1'b1;
    step(3);
    note_st(ST_SWSTBY);
    note(2, 12'h1ff, 12'h000);
    cfg.standby_output_keep = 1'b1;
    step(2);
    note(2, 12'h1ff, 12'h1ff);
    note(1, 12'h1ff, 12'h1ff);
    cfg.wait_input_enable = 1'b1;
    step(2);
    note(2, 12'h100, 12'h000);
    sw_standby_req = 1'b0;
    wake_req = 1'b1;
    step(2);
    wake_req = 1'b0;
    stall = 1'b1;
    step(3);
    note_st(ST_EXEC);
    note(6, 12'h001, 12'h000);
    stall = 1'b0;
    step(3);
    note(6, 12'h001, 12'h001);
    $display("test sw_standby done");
    cfg.bus_release_allow = 1'b1;
    step(2);
    note(1, 12'h200, 12'h200);
    bus_request_input_req = 1'b1;
    step(4);
    note_st(ST_BREL);
    note(5, 12'h001, 12'h001);
    note(2, 12'h30f, 12'h200);
    note(1, 12'h200, 12'h000);
    bus_request_input_req = 1'b0;
    step(3);
    note_st(ST_EXEC);
    $display("test bus_release done");
    // a frozen clock enable must hold off a manual reset request
    clk_en = 1'b0;
    manual_reset_req = 1'b1;
    step(3);
    note_st(ST_EXEC);
    manual_reset_req = 1'b0;
    clk_en = 1'b1;
    cfg.bus_request_out_enable = 1'b1;
    cfg.dram_space_select = 1'b1;
    fn_o = 12'h100;
    step(2);
    note(2, 12'h900, 12'h900);
    note(1, 12'h900, 12'h100);
    bus_request_input_req = 1'b1;
    step(4);
    note_st(ST_BREL);
    note(2, 12'h900, 12'h100);
    bus_request_input_req = 1'b0;
    sw_standby_req = 1'b1;
    step(4);
    note_st(ST_SWSTBY);
    note(2, 12'h900, 12'h800);
    note(1, 12'h800, 12'h000);
    sw_standby_req = 1'b0;
    wake_req = 1'b1;
    step(2);
    wake_req = 1'b0;
    note_st(ST_EXEC);
    $display("test modes done");
    reset_pin_n = 1'b0;
    step(12);
    standby_pin = 1'b0;
    step(3);
    note_st(ST_HWSTBY);
    note(2, 12'hfff, 12'h000);
    note(4, 12'h001, 12'h000);
    step(14);
    standby_pin = 1'b1;
    step(4);
    note_st(ST_POR);
    $display("test hw_standby done");
    reset_pin_n = 1'b1;
    step(2);
    note_st(ST_EXEC);
    standby_pin = 1'b0;
    step(3);
    note_st(ST_HWSTBY);
    note(2, 12'hfff, 12'h000);
    reset_pin_n = 1'b0;
    step(14);
    standby_pin = 1'b1;
    step(4);
    note_st(ST_POR);
    $display("test hw_standby_no_reset done");
    step(1);
    conclude();
  end
endmodule : bus_pin_state_control_bench
